// ===== verilog/cci_irq_routing.v
// Interrupt enable and service line routing for a three-channel
// capture/compare timer unit, with suspend, disable and run control.
// Assumes an 8-bit peripheral register port on the peripheral clock and
// one-cycle flag-set pulses from the timer kernel on the same clock.
// The system levels may change at any time relative to the clock.
//
// Function
// - One-match enable bit 6 gates timer A one-match onto its pointer's line.
// - Channel 2 fall/rise enables bits 5/4 gate events to channel 2 line.
// - Channel 1 fall/rise enables bits 3/2 gate events to channel 1 line.
// - Channel 0 fall/rise enables bits 1/0 gate events to channel 0 line.
// - Enable register resets to zero; no interrupt until software enables.
// - Two-bit pointer codes 00..11 select lines 0..3; only enabled events.
// - Bits 13:12 route timer B compare and period events.
// - Bits 11:10 route timer A one-match and period events.
// - Bits 9:8 route trap and wrong hall events.
// - Bits 7:6 route correct hall and shadow transfer events.
// - Channel pointers: ch2 bits 5:4, ch1 bits 3:2, ch0 bits 1:0.
// - Pointer bits 15:14 ignore writes and read zero.
// - Pointer register resets to 3940 hex.
// - Service lines carry pulses; sources sharing a line are ORed.
// - Kernel runs on the peripheral clock at its frequency.
// - Debug suspend stops flagged timers, forces passive outputs, freezes inputs.
// - Disable request stops timers, passive outputs, freezes inputs, gates clock.
// - Both timer hardware run inputs come from the second timer status.
// - Registers reached over an 8-bit bus with clock gating and decode.
// - Upper enable bits hold shadow, idle, hall, trap, timer events; bit 11 reserved.
`timescale 1ns/1ns
`include "cci_regs.vh"
module cci_irq_routing #(
    parameter LINES = 4,
    parameter EVENTS = 16
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // 8-bit peripheral register port
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_write,
    input wire bus_read,
    output reg [7:0] bus_rdata_ff,
    output wire bus_hit,
    // Flag set conditions from the kernel, one-cycle pulses
    input wire ch0_rise_set,
    input wire ch0_fall_set,
    input wire ch1_rise_set,
    input wire ch1_fall_set,
    input wire ch2_rise_set,
    input wire ch2_fall_set,
    input wire timer_a_one_match_flag,
    input wire timer_a_period_flag,
    input wire timer_b_compare_flag,
    input wire timer_b_period_flag,
    input wire trap_flag,
    input wire correct_hall_flag,
    input wire wrong_hall_flag,
    input wire shadow_transfer_flag,
    // System control and debug (asynchronous levels)
    input wire debug_suspend,
    input wire timer_a_suspend_en,
    input wire timer_b_suspend_en,
    input wire unit_disable_req,
    input wire second_timer_status,
    // Service lines and kernel control
    output reg [LINES-1:0] service_lines_ff,
    output wire timer_a_hw_run,
    output wire timer_b_hw_run,
    output wire timer_a_stop,
    output wire timer_b_stop,
    output wire outputs_passive,
    output wire inputs_frozen,
    output wire auto_idle_en,
    output wire kernel_clk_en
);
    // ==========================================
    // Map and timing summary
    // Enable register: low byte at 0x44, high byte at 0x45. Line select
    // register: low byte at 0x48, high byte at 0x49. Bytes are written and
    // read on their own, so a 16-bit update is not atomic: an event that
    // falls between the two byte writes is routed by a half-new pointer.
    // A flag-set pulse seen at edge N with its enable set gives a one-cycle
    // pulse on the chosen service line after edge N; the line is low again
    // after edge N+1 unless another enabled event came in that cycle.
    // System levels take two edges through the synchroniser before suspend,
    // disable or the hardware run outputs react to them.
    // Limitation: the clock enable does not stall the synchroniser, so a level
    // that changes while the enable is low is still seen two edges later.

    // ==========================================
    // Registers
    reg [15:0] irq_enable_ff;
    reg [15:0] irq_line_select_ff;
    reg [1:0] gate_seq_ff;
    wire [4:0] sys_sync;
    wire dbg_s, susp_a_s, susp_b_s, dis_s, run_s;
    wire [EVENTS-1:0] flags;
    wire [EVENTS-1:0] hit;
    // One request vector per event group, seven groups in all
    wire [LINES-1:0] grp_req [0:6];
    wire [LINES-1:0] nxt_service_lines;
    wire susp_a, susp_b;
    wire wr_ok;
    reg [7:0] nxt_rdata;
    // Writable bits per register; reserved bits stay zero whatever is written
    wire [15:0] enable_wmask;
    wire [15:0] line_wmask;

    // ==========================================
    // System levels pass a two-stage synchroniser
    // The five levels are independent, so a one-cycle skew between them
    // after synchronising is harmless; they share one chain to save code.
    cci_sync2 #(.WIDTH(5)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({debug_suspend, timer_a_suspend_en, timer_b_suspend_en, unit_disable_req, second_timer_status}),
        .sync_out(sys_sync)
    );
    assign dbg_s = sys_sync[4];
    assign susp_a_s = sys_sync[3];
    assign susp_b_s = sys_sync[2];
    assign dis_s = sys_sync[1];
    assign run_s = sys_sync[0];

    // ==========================================
    // Suspend and disable control
    // A debug suspend holds only a timer whose suspend bit is set; a disable
    // request holds both whatever the suspend bits say. Freezing the inputs
    // while either timer is held keeps a half-frozen kernel from firing.
    assign susp_a = (dbg_s & susp_a_s) | dis_s;
    assign susp_b = (dbg_s & susp_b_s) | dis_s;
    assign timer_a_stop = susp_a;
    assign timer_b_stop = susp_b;
    // Trap-enabled outputs go passive while either timer is held
    assign outputs_passive = susp_a | susp_b;
    assign inputs_frozen = susp_a | susp_b;
    // Hardware run for both timers from the second timer status
    assign timer_a_hw_run = run_s;
    assign timer_b_hw_run = run_s;
    assign auto_idle_en = irq_enable_ff[`CCI_EN_AUTO_IDLE];

    // Disable sequence: stop and freeze first, gate kernel clock two cycles
    // later so the freeze has settled before the clock dies.
    // The bus side keeps its clock, so the registers stay reachable and a
    // cleared request restarts the kernel without a reset.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_seq_ff <= 2'h0;
        end else if (clk_en) begin
            gate_seq_ff <= dis_s ? {gate_seq_ff[0], 1'b1} : 2'h0;
        end
    end
    // Kernel clock is the peripheral clock unless gated off
    assign kernel_clk_en = clk_en & ~gate_seq_ff[1];

    // ==========================================
    // Register decode; the bus interface keeps working while kernel gated
    assign bus_hit = (bus_addr == `CCI_OFS_ENABLE_LO) | (bus_addr == `CCI_OFS_ENABLE_HI) |
                     (bus_addr == `CCI_OFS_LINE_LO) | (bus_addr == `CCI_OFS_LINE_HI);
    assign wr_ok = bus_write & clk_en;
    assign enable_wmask = `CCI_ENABLE_WMASK;
    assign line_wmask = `CCI_LINE_WMASK;

    // Writes need the clock enable; an unmapped address changes nothing,
    // and reserved bits are masked so they always read back as zero.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_enable_ff <= `CCI_ENABLE_RST;
            irq_line_select_ff <= `CCI_LINE_RST;
        end else if (wr_ok) begin
            case (bus_addr)
                `CCI_OFS_ENABLE_LO: begin
                    irq_enable_ff[7:0] <= bus_wdata;
                end
                `CCI_OFS_ENABLE_HI: begin
                    irq_enable_ff[15:8] <= bus_wdata & enable_wmask[15:8];
                end
                `CCI_OFS_LINE_LO: begin
                    irq_line_select_ff[7:0] <= bus_wdata;
                end
                `CCI_OFS_LINE_HI: begin
                    irq_line_select_ff[15:8] <= bus_wdata & line_wmask[15:8];
                end
                default: begin
                    irq_enable_ff <= irq_enable_ff;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    // Reserved bits read zero because the write masks never let them set
    always @* begin
        case (bus_addr)
            `CCI_OFS_ENABLE_LO: nxt_rdata = irq_enable_ff[7:0];
            `CCI_OFS_ENABLE_HI: nxt_rdata = irq_enable_ff[15:8];
            `CCI_OFS_LINE_LO: nxt_rdata = irq_line_select_ff[7:0];
            `CCI_OFS_LINE_HI: nxt_rdata = irq_line_select_ff[15:8];
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data is registered and holds until the next read, so the master
    // may take it at any edge after the read edge.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata_ff <= 8'h00;
        end else if (clk_en & bus_read) begin
            bus_rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================
    // Event gating by enable bits; position equals enable bit index
    // Pack each set condition at the index of its enable bit; the idle control
    // and reserved positions are tied low so they can never raise a line.
    assign flags[`CCI_EN_CH0_RISE] = ch0_rise_set;
    assign flags[`CCI_EN_CH0_FALL] = ch0_fall_set;
    assign flags[`CCI_EN_CH1_RISE] = ch1_rise_set;
    assign flags[`CCI_EN_CH1_FALL] = ch1_fall_set;
    assign flags[`CCI_EN_CH2_RISE] = ch2_rise_set;
    assign flags[`CCI_EN_CH2_FALL] = ch2_fall_set;
    assign flags[`CCI_EN_ONE_MATCH] = timer_a_one_match_flag;
    assign flags[`CCI_EN_A_PERIOD] = timer_a_period_flag;
    assign flags[`CCI_EN_B_COMPARE] = timer_b_compare_flag;
    assign flags[`CCI_EN_B_PERIOD] = timer_b_period_flag;
    assign flags[`CCI_EN_TRAP] = trap_flag;
    assign flags[`CCI_EN_RESERVED] = 1'b0;
    assign flags[`CCI_EN_HALL_OK] = correct_hall_flag;
    assign flags[`CCI_EN_WRONG_HALL] = wrong_hall_flag;
    assign flags[`CCI_EN_AUTO_IDLE] = 1'b0;
    assign flags[`CCI_EN_SHADOW] = shadow_transfer_flag;
    // Frozen inputs raise no events; bit 14 is idle control, bit 11 reserved
    assign hit = flags & irq_enable_ff & {EVENTS{~inputs_frozen}};

    // ==========================================
    // Group routing through the line pointers
    // Channel 0 rising and falling events share one pointer
    cci_line_route #(.LINES(LINES)) u_ch0 (
        .event_hit(hit[`CCI_EN_CH0_RISE] | hit[`CCI_EN_CH0_FALL]),
        .line_sel(irq_line_select_ff[`CCI_SEL_CH0+1:`CCI_SEL_CH0]),
        .line_req(grp_req[0])
    );

    // Channel 1 rising and falling events share one pointer
    cci_line_route #(.LINES(LINES)) u_ch1 (
        .event_hit(hit[`CCI_EN_CH1_RISE] | hit[`CCI_EN_CH1_FALL]),
        .line_sel(irq_line_select_ff[`CCI_SEL_CH1+1:`CCI_SEL_CH1]),
        .line_req(grp_req[1])
    );

    // Channel 2 rising and falling events share one pointer
    cci_line_route #(.LINES(LINES)) u_ch2 (
        .event_hit(hit[`CCI_EN_CH2_RISE] | hit[`CCI_EN_CH2_FALL]),
        .line_sel(irq_line_select_ff[`CCI_SEL_CH2+1:`CCI_SEL_CH2]),
        .line_req(grp_req[2])
    );

    // Correct hall and shadow transfer share the hall pointer
    cci_line_route #(.LINES(LINES)) u_hall (
        .event_hit(hit[`CCI_EN_HALL_OK] | hit[`CCI_EN_SHADOW]),
        .line_sel(irq_line_select_ff[`CCI_SEL_HALL_OK+1:`CCI_SEL_HALL_OK]),
        .line_req(grp_req[3])
    );

    // Trap and wrong hall share the error pointer
    cci_line_route #(.LINES(LINES)) u_err (
        .event_hit(hit[`CCI_EN_TRAP] | hit[`CCI_EN_WRONG_HALL]),
        .line_sel(irq_line_select_ff[`CCI_SEL_ERROR+1:`CCI_SEL_ERROR]),
        .line_req(grp_req[4])
    );

    // Timer A one-match and period-match share the timer A pointer
    cci_line_route #(.LINES(LINES)) u_ta (
        .event_hit(hit[`CCI_EN_ONE_MATCH] | hit[`CCI_EN_A_PERIOD]),
        .line_sel(irq_line_select_ff[`CCI_SEL_TIMER_A+1:`CCI_SEL_TIMER_A]),
        .line_req(grp_req[5])
    );

    // Timer B compare-match and period-match share the timer B pointer
    cci_line_route #(.LINES(LINES)) u_tb (
        .event_hit(hit[`CCI_EN_B_COMPARE] | hit[`CCI_EN_B_PERIOD]),
        .line_sel(irq_line_select_ff[`CCI_SEL_TIMER_B+1:`CCI_SEL_TIMER_B]),
        .line_req(grp_req[6])
    );

    // Shared lines OR every group aimed at them
    assign nxt_service_lines = grp_req[0] | grp_req[1] | grp_req[2] | grp_req[3] |
                               grp_req[4] | grp_req[5] | grp_req[6];

    // ==========================================
    // One-cycle pulse registered the cycle after the event; a gated kernel
    // emits nothing, so stale pulses cannot survive a clock stop.
    // Pulses are not stretched: the interrupt node must sample on this same
    // clock, or it may miss a request. A low clock enable holds the line as is.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            service_lines_ff <= {LINES{1'b0}};
        end else if (clk_en) begin
            service_lines_ff <= kernel_clk_en ? nxt_service_lines : {LINES{1'b0}};
        end
    end
endmodule // cci_irq_routing

// ===== verilog/cci_regs.vh
// Register map, field positions, reset values and event indices of the
// interrupt routing block. Definitions only.
`ifndef CCI_REGS_VH
`define CCI_REGS_VH

// Register byte offsets (enable offset shared with its page)
`define CCI_OFS_ENABLE_LO 8'h44
`define CCI_OFS_ENABLE_HI 8'h45
`define CCI_OFS_LINE_LO 8'h48
`define CCI_OFS_LINE_HI 8'h49

// Reset values and write masks
`define CCI_ENABLE_RST 16'h0000
`define CCI_LINE_RST 16'h3940
`define CCI_ENABLE_WMASK 16'hf7ff
`define CCI_LINE_WMASK 16'h3fff

// Enable bit positions
`define CCI_EN_CH0_RISE 0
`define CCI_EN_CH0_FALL 1
`define CCI_EN_CH1_RISE 2
`define CCI_EN_CH1_FALL 3
`define CCI_EN_CH2_RISE 4
`define CCI_EN_CH2_FALL 5
`define CCI_EN_ONE_MATCH 6
`define CCI_EN_A_PERIOD 7
`define CCI_EN_B_COMPARE 8
`define CCI_EN_B_PERIOD 9
`define CCI_EN_TRAP 10
`define CCI_EN_RESERVED 11
`define CCI_EN_HALL_OK 12
`define CCI_EN_WRONG_HALL 13
`define CCI_EN_AUTO_IDLE 14
`define CCI_EN_SHADOW 15

// Line select field low positions (each field two bits wide)
`define CCI_SEL_CH0 0
`define CCI_SEL_CH1 2
`define CCI_SEL_CH2 4
`define CCI_SEL_HALL_OK 6
`define CCI_SEL_ERROR 8
`define CCI_SEL_TIMER_A 10
`define CCI_SEL_TIMER_B 12

// Event count and service line count
`define CCI_NUM_EVENTS 16
`define CCI_NUM_LINES 4

`endif

// ===== verilog/cci_sync2.v
// Two flip-flop synchroniser for a bus of levels.
// Assumes inputs come from another clock domain or a pin.
`timescale 1ns/1ns
module cci_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire reset_n,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stable_ff;

    // ==========================================
    // Synchroniser chain; first stage feeds only the second
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= {WIDTH{1'b0}};
            stable_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule // cci_sync2

// ===== verilog/cci_line_route.v
// Steers one event group onto one of four service lines.
// Assumes event and selector come from the same clock domain.
`timescale 1ns/1ns
module cci_line_route #(
    parameter LINES = 4
) (
    input wire event_hit,
    input wire [1:0] line_sel,
    output reg [LINES-1:0] line_req
);
    integer i;

    // ==========================================
    // Decode the pointer; only the chosen line sees the hit
    always @* begin
        line_req = {LINES{1'b0}};
        for (i = 0; i < LINES; i = i + 1) begin
            if (line_sel == i[1:0]) begin
                line_req[i] = event_hit;
            end
        end
    end
endmodule // cci_line_route

// ===== verif/cci_irq_routing_monitor.sv
// Port-level checker for the interrupt routing block.
// Assumes it is bound to cci_irq_routing and sees only its ports.
`timescale 1ns/1ns
module cci_irq_monitor #(
    parameter LINES = 4
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire [7:0] bus_addr,
    input wire bus_read,
    input wire [7:0] bus_rdata_ff,
    input wire bus_hit,
    input wire [LINES-1:0] service_lines_ff,
    input wire debug_suspend,
    input wire timer_a_suspend_en,
    input wire timer_b_suspend_en,
    input wire unit_disable_req,
    input wire second_timer_status,
    input wire timer_a_hw_run,
    input wire timer_a_stop,
    input wire timer_b_stop,
    input wire outputs_passive,
    input wire inputs_frozen,
    input wire kernel_clk_en
);
    reg [1:0] up_ff;
    // =======
    // Cycles since reset; $past values before this are from reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) up_ff <= 2'h0;
        else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // =======
    // Properties
    property p_run;
        up_ff == 2'h3 |-> timer_a_hw_run == $past(second_timer_status, 2);
    endproperty
    a_run: assert property (p_run) else $error("hw run not following status");
    property p_stop_a;
        up_ff == 2'h3 |-> timer_a_stop == (($past(debug_suspend, 2) && $past(timer_a_suspend_en, 2))
            || $past(unit_disable_req, 2));
    endproperty
    a_stop_a: assert property (p_stop_a) else $error("timer a stop wrong");
    property p_stop_b;
        up_ff == 2'h3 |-> timer_b_stop == (($past(debug_suspend, 2) && $past(timer_b_suspend_en, 2))
            || $past(unit_disable_req, 2));
    endproperty
    a_stop_b: assert property (p_stop_b) else $error("timer b stop wrong");
    property p_frozen;
        inputs_frozen == (timer_a_stop || timer_b_stop) && outputs_passive == inputs_frozen;
    endproperty
    a_frozen: assert property (p_frozen) else $error("freeze not tied to stops");
    property p_quiet;
        inputs_frozen |=> service_lines_ff == '0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("line pulse while frozen");
    property p_gate;
        (unit_disable_req && clk_en) [*6] |-> !kernel_clk_en;
    endproperty
    a_gate: assert property (p_gate) else $error("kernel clock not gated");
    property p_hit;
        bus_hit == (bus_addr == 8'h44 || bus_addr == 8'h45 || bus_addr == 8'h48 || bus_addr == 8'h49);
    endproperty
    a_hit: assert property (p_hit) else $error("address decode wrong");
    property p_unmapped;
        bus_read && clk_en && !bus_hit |=> bus_rdata_ff == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_res;
        bus_read && clk_en && bus_addr == 8'h49 |=> bus_rdata_ff[7:6] == 2'h0;
    endproperty
    a_res: assert property (p_res) else $error("reserved pointer bits read one");
    property p_hold;
        !(bus_read && clk_en) |=> $stable(bus_rdata_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("read data changed without read");
endmodule // cci_irq_monitor

bind cci_irq_routing cci_irq_monitor #(.LINES(LINES)) u_mon (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .bus_addr(bus_addr), .bus_read(bus_read), .bus_rdata_ff(bus_rdata_ff), .bus_hit(bus_hit),
    .service_lines_ff(service_lines_ff), .debug_suspend(debug_suspend), .timer_a_suspend_en(timer_a_suspend_en),
    .timer_b_suspend_en(timer_b_suspend_en), .unit_disable_req(unit_disable_req),
    .second_timer_status(second_timer_status), .timer_a_hw_run(timer_a_hw_run), .timer_a_stop(timer_a_stop),
    .timer_b_stop(timer_b_stop), .outputs_passive(outputs_passive), .inputs_frozen(inputs_frozen),
    .kernel_clk_en(kernel_clk_en));

// ===== verif/cci_sr_sink.sv
// Model of the interrupt node side: counts service line pulses.
// Assumes lines are sampled on the unit's own clock.
`timescale 1ns/1ns
module cci_sr_sink #(
    parameter LINES = 4
) (
    input wire clk,
    input wire reset_n,
    input wire [LINES-1:0] service_lines,
    output reg [8*LINES-1:0] pulse_cnt_ff
);
    integer i;
    // =======
    // Each high cycle is one request; shared sources arrive already merged
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) pulse_cnt_ff <= '0;
        else for (i = 0; i < LINES; i = i + 1) begin
            if (service_lines[i]) pulse_cnt_ff[8*i +: 8] <= pulse_cnt_ff[8*i +: 8] + 8'h01;
        end
    end
endmodule // cci_sr_sink

// ===== verif/cci_tb.sv
// Self-checking bench for the interrupt routing block.
// Assumes the design files and the line sink model are compiled first.
`timescale 1ns/1ns
module testbench;
    reg clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, bus_write = 1'b0, bus_read = 1'b0;
    reg [7:0] bus_addr = 8'h00, bus_wdata = 8'h00;
    reg [15:0] ev = 16'h0000;
    reg [4:0] sys = 5'h00;
    wire [7:0] rdata;
    wire [3:0] lines;
    wire [31:0] cnt;
    wire run_a, run_b, stop_a, stop_b, passive, frozen, kclk, idle;
    integer n_mismatch = 0, compares = 0, cyc = 0;
    cci_irq_routing u_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata_ff(rdata), .bus_hit(),
        .ch0_rise_set(ev[0]), .ch0_fall_set(ev[1]), .ch1_rise_set(ev[2]), .ch1_fall_set(ev[3]),
        .ch2_rise_set(ev[4]), .ch2_fall_set(ev[5]), .timer_a_one_match_flag(ev[6]), .timer_a_period_flag(ev[7]),
        .timer_b_compare_flag(ev[8]), .timer_b_period_flag(ev[9]), .trap_flag(ev[10]), .correct_hall_flag(ev[12]),
        .wrong_hall_flag(ev[13]), .shadow_transfer_flag(ev[15]), .debug_suspend(sys[0]),
        .timer_a_suspend_en(sys[1]), .timer_b_suspend_en(sys[2]), .unit_disable_req(sys[3]),
        .second_timer_status(sys[4]), .service_lines_ff(lines), .timer_a_hw_run(run_a), .timer_b_hw_run(run_b),
        .timer_a_stop(stop_a), .timer_b_stop(stop_b), .outputs_passive(passive), .inputs_frozen(frozen),
        .auto_idle_en(idle), .kernel_clk_en(kclk));
    cci_sr_sink u_sink (.clk(clk), .reset_n(reset_n), .service_lines(lines), .pulse_cnt_ff(cnt));
    // =======
    // Clock and hang guard; the run needs about 630 cycles
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end
    // =======
    // Shared tasks
    task chk(input [15:0] seen, input [15:0] exp, input string what);
        compares = compares + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_write = 1'b1;
        @(negedge clk);
        bus_write = 1'b0;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_read = 1'b1;
        @(negedge clk);
        bus_read = 1'b0;
        d = rdata;
    endtask
    task wr16(input [7:0] a, input [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    task rd16(input [7:0] a, output [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h01, v[15:8]);
    endtask
    // Pulse flags for one cycle; l1 is the cycle after, l2 the one after that
    task fire(input [15:0] m, output [3:0] l1, output [3:0] l2);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 16'h0000;
        l1 = lines;
        @(negedge clk);
        l2 = lines;
    endtask
    function integer pos(input integer b);
        case (b)
            0, 1: pos = 0;
            2, 3: pos = 2;
            4, 5: pos = 4;
            6, 7: pos = 10;
            8, 9: pos = 12;
            10, 13: pos = 8;
            default: pos = 6;
        endcase
    endfunction
    // =======
    // Scenarios
    task t_regs;
        reg [15:0] v;
        reg [7:0] d;
        rd16(8'h44, v);
        chk(v, 16'h0000, "enable reset");
        rd16(8'h48, v);
        chk(v, 16'h3940, "pointer reset");
        wr16(8'h48, 16'hffff);
        rd16(8'h48, v);
        chk(v, 16'h3fff, "pointer reserved");
        wr16(8'h44, 16'hffff);
        rd16(8'h44, v);
        chk(v, 16'hf7ff, "enable reserved");
        chk(idle, 1'b1, "auto idle on");
        rd(8'h50, d);
        chk(d, 8'h00, "unmapped read");
        clk_en = 1'b0;
        wr(8'h48, 8'h00);
        clk_en = 1'b1;
        rd(8'h48, d);
        chk(d, 8'hff, "write without enable");
        wr16(8'h44, 16'h0000);
        chk(idle, 1'b0, "auto idle off");
    endtask
    task t_route;
        integer b, c;
        reg [3:0] l1, l2;
        for (b = 0; b < 16; b = b + 1) if (b != 11 && b != 14) begin
            wr16(8'h44, 16'h0001 << b);
            for (c = 0; c < 4; c = c + 1) begin
                wr16(8'h48, 16'(c) << pos(b));
                fire(16'h0001 << b, l1, l2);
                chk(l1, 4'h1 << c, "routed line");
                chk(l2, 4'h0, "pulse length");
            end
            wr16(8'h44, ~(16'h0001 << b) & 16'hb7ff);
            fire(16'h0001 << b, l1, l2);
            chk(l1, 4'h0, "disabled event");
        end
    endtask
    task t_share;
        reg [3:0] l1, l2;
        reg [7:0] n0;
        wr16(8'h48, 16'h0000);
        wr16(8'h44, 16'h0005);
        n0 = cnt[7:0];
        fire(16'h0005, l1, l2);
        chk(l1, 4'h1, "shared line");
        chk(cnt[7:0], n0 + 8'h01, "sink pulse count");
    endtask
    task t_system;
        reg [3:0] l1, l2;
        sys = 5'h13;
        repeat (4) @(negedge clk);
        chk({run_a, run_b}, 2'h3, "hw run");
        chk({stop_a, stop_b, passive, frozen}, 4'hb, "suspend outputs");
        fire(16'h0001, l1, l2);
        chk(l1, 4'h0, "frozen event");
        sys = 5'h05;
        repeat (4) @(negedge clk);
        chk({stop_a, stop_b, passive, frozen}, 4'h7, "timer b suspend");
        sys = 5'h06;
        repeat (4) @(negedge clk);
        chk({stop_a, stop_b, passive, frozen}, 4'h0, "suspend bits without debug");
        sys = 5'h00;
        repeat (4) @(negedge clk);
        chk({run_a, run_b}, 2'h0, "hw run off");
        fire(16'h0001, l1, l2);
        chk(l1, 4'h1, "event after suspend");
        sys = 5'h08;
        repeat (8) @(negedge clk);
        chk({stop_a, stop_b, passive, frozen, kclk}, 5'h1e, "disable outputs");
    endtask
    task end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // =======
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        t_regs;
        t_route;
        t_share;
        t_system;
        end_of_test;
    end
endmodule // testbench
